// *** jog_home_defs.svh ***
// Constants for the jog and homing control block
`ifndef JOG_HOME_DEFS_SVH
`define JOG_HOME_DEFS_SVH
`define JH_TEL_SPEED_A     8'd7
`define JH_TEL_SPEED_B     8'd9
`define JH_TEL_POS_FIRST   8'd111
`define JH_TEL_POS_LAST    8'd113
`define JH_CW1_JOG1_BIT    8
`define JH_CW1_JOG2_BIT    9
`define JH_CW2_JOGINC_BIT  5
`define JH_REFCAM_DI_SEL   1'b1
`define JH_POS_RESET       32'h00000000
`define JH_VEL_RESET       32'h00000000
`endif

// *** jog_home_pkg.sv ***
// Types shared by the jog and homing control block
package jog_home_pkg;
	typedef enum {
		JOG_IDLE,
		JOG_VEL,
		JOG_INC
	} jog_state_t;
	typedef enum {
		HOME_IDLE,
		HOME_TO_CAM,
		HOME_TO_MARK,
		HOME_TO_POS
	} home_state_t;
	typedef enum logic [1:0] {
		MARK_ENCODER,
		MARK_DIGITAL,
		MARK_NO_CAM
	} home_mode_t;
endpackage : jog_home_pkg

// *** jog_select.sv ***
// Jog channel decoder from drive control word 1
`timescale 1ns/10ps
`include "jog_home_defs.svh"
module jog_select (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [15:0] driveControlWord1,
	output logic             jogStart1,
	output logic             jogStart2,
	output logic             jogHeld1,
	output logic             jogHeld2
);
	logic b8R;
	logic b9R;
	logic b8;
	logic b9;
	assign b8 = driveControlWord1[`JH_CW1_JOG1_BIT];
	assign b9 = driveControlWord1[`JH_CW1_JOG2_BIT];
	// Both set keeps the old setpoint, so neither start fires and holds stay
	always_comb begin
		jogStart1 = b8 && !b9 && !b8R; // [RULE_06]
		jogStart2 = b9 && !b8 && !b9R; // [RULE_06]
		jogHeld1  = b8;
		jogHeld2  = b9;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			b8R <= 1'b0;
			b9R <= 1'b0;
		end else begin
			b8R <= b8;
			b9R <= b9;
		end
	end
endmodule : jog_select

// *** jog_and_homing_control.sv ***
// Jog and homing control with safety velocity limit
//
// Notes on behaviour
// [RULE_01] Velocity above active safety limit while positioning stops motor and aborts move.
// [RULE_02] Speed limits come from active setpoint velocity limit elements 0 and 1.
// [RULE_03] Jog distances apply only when incremental select is 1; else endless velocity.
// [RULE_04] Incremental jog moves by the channel's distance at the channel's velocity.
// [RULE_05] Velocity jog runs at channel velocity and stops when the jog signal drops.
// [RULE_06] Control word 1 bits 8/9: none, jog1 edge, jog2 edge, both keep setpoint.
// [RULE_07] Telegrams 111 to 113: control word 2 bit 5 picks incremental or velocity.
// [RULE_08] Telegrams 7 and 9 always jog endlessly by velocity only.
// [RULE_09] Each channel has its own velocity and distance, chosen by its signal.
// [RULE_10] Active homing drives the axis to the home position and ends there.
// [RULE_11] Passive homing corrects actual position on the fly without own motion.
// [RULE_12] Absolute encoder adjustment loads reference coordinate as position, no motion.
// [RULE_13] Homing mark is encoder zero mark or digital input zero mark.
// [RULE_14] Reference cam from controller or converter input when its select is 1.
// [RULE_15] Mark position is home minus offset (active) or home (passive).
// [RULE_16] Reversing cam flips search direction while searching for the reference cam.
// [RULE_17] Three approach velocities: to cam, to zero mark, to home position.
`timescale 1ns/10ps
`include "jog_home_defs.svh"
module jog_and_homing_control
	import jog_home_pkg::*;
#(
	parameter int PW = 32,
	parameter int VW = 32
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic [7:0]           telegramNumber,
	input  wire logic [15:0]          driveControlWord1,
	input  wire logic [15:0]          positionControlWord2,
	input  wire logic                 jogIncrementalSelect,
	input  wire logic [VW-1:0]        jogChannel1Velocity,
	input  wire logic [VW-1:0]        jogChannel2Velocity,
	input  wire logic signed [PW-1:0] jogChannel1Distance,
	input  wire logic signed [PW-1:0] jogChannel2Distance,
	input  wire logic [VW-1:0]        activeSetpointVelocityLimit0,
	input  wire logic [VW-1:0]        activeSetpointVelocityLimit1,
	input  wire logic                 safetyMonitorActive,
	input  wire logic [VW-1:0]        motorVelocity,
	input  wire logic signed [PW-1:0] actualPosition,
	input  wire logic                 targetReached,
	input  wire logic                 activeHomingStart,
	input  wire logic                 passiveHomingEnable,
	input  wire logic                 absAdjustStart,
	input  wire logic signed [PW-1:0] homePosition,
	input  wire logic signed [PW-1:0] homeOffset,
	input  wire home_mode_t           homingMode,
	input  wire logic                 homingDirNeg,
	input  wire logic                 encoderZeroMark,
	input  wire logic                 externalZeroMark,
	input  wire logic                 controllerRefCam,
	input  wire logic                 inputRefCam,
	input  wire logic                 referenceCamInputSelect,
	input  wire logic                 reversingCam,
	input  wire logic [VW-1:0]        approachVelCam,
	input  wire logic [VW-1:0]        approachVelMark,
	input  wire logic [VW-1:0]        approachVelHome,
	output logic [VW-1:0]             speedLimitSourceA,
	output logic [VW-1:0]             speedLimitSourceB,
	output logic                      moveEnable,
	output logic                      moveIsVelocity,
	output logic                      moveDirNeg,
	output logic [VW-1:0]             moveVelocity,
	output logic signed [PW-1:0]      moveTarget,
	output logic                      positionLoad,
	output logic signed [PW-1:0]      positionLoadValue,
	output logic                      homed,
	output logic                      homingActive,
	output logic                      positioningAborted
);
	// ==========================================================
	// Jog channel decode
	logic jogStart1;
	logic jogStart2;
	logic jogHeld1;
	logic jogHeld2;
	jog_select u_sel (
		.clk_sys           (clk_sys),
		.rst               (rst),
		.driveControlWord1 (driveControlWord1),
		.jogStart1         (jogStart1),
		.jogStart2         (jogStart2),
		.jogHeld1          (jogHeld1),
		.jogHeld2          (jogHeld2)
	);

	// ==========================================================
	// Telegram and jog mode selection
	logic speedTel;
	logic posTel;
	logic incMode;
	logic refCam;
	logic homeMark;
	always_comb begin
		speedTel = (telegramNumber == `JH_TEL_SPEED_A) || (telegramNumber == `JH_TEL_SPEED_B);
		posTel   = (telegramNumber >= `JH_TEL_POS_FIRST) && (telegramNumber <= `JH_TEL_POS_LAST);
		// Speed telegrams never jog by distance
		if (speedTel)
			incMode = 1'b0; // [RULE_08]
		else if (posTel)
			incMode = positionControlWord2[`JH_CW2_JOGINC_BIT]; // [RULE_07]
		else
			incMode = jogIncrementalSelect; // [RULE_03]
		refCam = (referenceCamInputSelect == `JH_REFCAM_DI_SEL) ? inputRefCam
			: controllerRefCam; // [RULE_14]
		homeMark = (homingMode == MARK_DIGITAL) ? externalZeroMark
			: encoderZeroMark; // [RULE_13]
	end

	// ==========================================================
	// Motion state
	jog_state_t  jogSt_r;
	jog_state_t  jogSt_nxt;
	home_state_t homeSt_r;
	home_state_t homeSt_nxt;
	logic                 jogCh2_r;
	logic                 jogCh2_nxt;
	logic                 searchNeg_r;
	logic                 searchNeg_nxt;
	logic                 revCam_r;
	logic                 moveEnable_r;
	logic                 moveEnable_nxt;
	logic                 moveIsVel_r;
	logic                 moveIsVel_nxt;
	logic                 moveDirNeg_r;
	logic                 moveDirNeg_nxt;
	logic [VW-1:0]        moveVel_r;
	logic [VW-1:0]        moveVel_nxt;
	logic signed [PW-1:0] moveTarget_r;
	logic signed [PW-1:0] moveTarget_nxt;
	logic                 posLoad_r;
	logic                 posLoad_nxt;
	logic signed [PW-1:0] posLoadVal_r;
	logic signed [PW-1:0] posLoadVal_nxt;
	logic                 homed_r;
	logic                 homed_nxt;
	logic                 aborted_r;
	logic                 aborted_nxt;
	logic                 homingActive_r;
	logic [VW-1:0]        limA_r;
	logic [VW-1:0]        limB_r;
	logic                 overLimit;
	logic                 chVelSel;
	logic signed [PW-1:0] chDist;
	logic [VW-1:0]        chVel;

	always_comb begin
		jogSt_nxt      = jogSt_r;
		homeSt_nxt     = homeSt_r;
		jogCh2_nxt     = jogCh2_r;
		searchNeg_nxt  = searchNeg_r;
		moveEnable_nxt = moveEnable_r;
		moveIsVel_nxt  = moveIsVel_r;
		moveDirNeg_nxt = moveDirNeg_r;
		moveVel_nxt    = moveVel_r;
		moveTarget_nxt = moveTarget_r;
		posLoad_nxt    = 1'b0;
		posLoadVal_nxt = posLoadVal_r;
		homed_nxt      = homed_r;
		aborted_nxt    = aborted_r;
		chVelSel       = jogStart2;
		chVel          = chVelSel ? jogChannel2Velocity : jogChannel1Velocity; // [RULE_09]
		chDist         = chVelSel ? jogChannel2Distance : jogChannel1Distance; // [RULE_09]
		overLimit      = safetyMonitorActive && moveEnable_r
			&& ((motorVelocity > limA_r) || (motorVelocity > limB_r));

		if (jogStart1 || jogStart2 || activeHomingStart)
			aborted_nxt = 1'b0;

		// Jog
		case (jogSt_r)
			JOG_IDLE: begin
				if ((jogStart1 || jogStart2) && homeSt_r == HOME_IDLE) begin
					jogCh2_nxt     = jogStart2;
					moveEnable_nxt = 1'b1;
					moveVel_nxt    = chVel;
					if (incMode) begin
						jogSt_nxt      = JOG_INC;
						moveIsVel_nxt  = 1'b0;
						moveDirNeg_nxt = chDist[PW-1];
						moveTarget_nxt = actualPosition + chDist; // [RULE_04]
					end else begin
						jogSt_nxt      = JOG_VEL;
						moveIsVel_nxt  = 1'b1; // [RULE_05]
						moveDirNeg_nxt = 1'b0;
					end
				end
			end
			JOG_VEL: begin
				// Stop as soon as the owning channel signal drops
				if (!(jogCh2_r ? jogHeld2 : jogHeld1)) begin
					jogSt_nxt      = JOG_IDLE;
					moveEnable_nxt = 1'b0; // [RULE_05]
				end
			end
			JOG_INC: begin
				if (targetReached) begin
					jogSt_nxt      = JOG_IDLE;
					moveEnable_nxt = 1'b0; // [RULE_04]
				end
			end
			default: jogSt_nxt = JOG_IDLE;
		endcase

		// Active homing
		case (homeSt_r)
			HOME_IDLE: begin
				if (activeHomingStart && jogSt_r == JOG_IDLE && !(jogStart1 || jogStart2)) begin
					homed_nxt      = 1'b0;
					searchNeg_nxt  = homingDirNeg;
					moveEnable_nxt = 1'b1;
					moveIsVel_nxt  = 1'b1;
					moveDirNeg_nxt = homingDirNeg;
					if (homingMode == MARK_ENCODER) begin
						homeSt_nxt  = HOME_TO_CAM;
						moveVel_nxt = approachVelCam; // [RULE_17]
					end else begin
						homeSt_nxt  = HOME_TO_MARK;
						moveVel_nxt = approachVelMark; // [RULE_17]
					end
				end
			end
			HOME_TO_CAM: begin
				if (refCam) begin
					homeSt_nxt  = HOME_TO_MARK;
					moveVel_nxt = approachVelMark; // [RULE_17]
				end else if (reversingCam && !revCam_r) begin
					searchNeg_nxt  = !searchNeg_r; // [RULE_16]
					moveDirNeg_nxt = !searchNeg_r; // [RULE_16]
				end
			end
			HOME_TO_MARK: begin
				if (homeMark) begin
					// Mark maps to home minus offset, then drive to home
					homeSt_nxt     = HOME_TO_POS;
					posLoad_nxt    = 1'b1;
					posLoadVal_nxt = homePosition - homeOffset; // [RULE_15]
					moveIsVel_nxt  = 1'b0;
					moveVel_nxt    = approachVelHome; // [RULE_17]
					moveTarget_nxt = homePosition; // [RULE_10]
					moveDirNeg_nxt = homeOffset[PW-1];
				end
			end
			HOME_TO_POS: begin
				if (targetReached && !posLoad_r) begin
					homeSt_nxt     = HOME_IDLE;
					moveEnable_nxt = 1'b0;
					homed_nxt      = 1'b1; // [RULE_10]
				end
			end
			default: homeSt_nxt = HOME_IDLE;
		endcase

		// Adjustment overrides any mark load above; passive homing loads only while homing is idle
		if (absAdjustStart) begin
			posLoad_nxt    = 1'b1;
			posLoadVal_nxt = homePosition; // [RULE_12]
			homed_nxt      = 1'b1;
		end else if (passiveHomingEnable && homeMark && homeSt_r == HOME_IDLE) begin
			posLoad_nxt    = 1'b1;
			posLoadVal_nxt = homePosition; // [RULE_11] [RULE_15]
			homed_nxt      = 1'b1;
		end

		// Safety trip beats every other motion decision
		if (overLimit) begin
			jogSt_nxt      = JOG_IDLE;
			homeSt_nxt     = HOME_IDLE;
			moveEnable_nxt = 1'b0; // [RULE_01]
			aborted_nxt    = 1'b1; // [RULE_01]
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			jogSt_r      <= JOG_IDLE;
			homeSt_r     <= HOME_IDLE;
			jogCh2_r     <= 1'b0;
			searchNeg_r  <= 1'b0;
			revCam_r     <= 1'b0;
			moveEnable_r <= 1'b0;
			moveIsVel_r  <= 1'b0;
			moveDirNeg_r <= 1'b0;
			moveVel_r    <= `JH_VEL_RESET;
			moveTarget_r <= `JH_POS_RESET;
			posLoad_r    <= 1'b0;
			posLoadVal_r <= `JH_POS_RESET;
			homed_r      <= 1'b0;
			aborted_r    <= 1'b0;
			homingActive_r <= 1'b0;
			limA_r       <= `JH_VEL_RESET;
			limB_r       <= `JH_VEL_RESET;
		end else begin
			jogSt_r      <= jogSt_nxt;
			homeSt_r     <= homeSt_nxt;
			jogCh2_r     <= jogCh2_nxt;
			searchNeg_r  <= searchNeg_nxt;
			revCam_r     <= reversingCam;
			moveEnable_r <= moveEnable_nxt;
			moveIsVel_r  <= moveIsVel_nxt;
			moveDirNeg_r <= moveDirNeg_nxt;
			moveVel_r    <= moveVel_nxt;
			moveTarget_r <= moveTarget_nxt;
			posLoad_r    <= posLoad_nxt;
			posLoadVal_r <= posLoadVal_nxt;
			homed_r      <= homed_nxt;
			aborted_r    <= aborted_nxt;
			homingActive_r <= (homeSt_nxt != HOME_IDLE);
			limA_r       <= activeSetpointVelocityLimit0; // [RULE_02]
			limB_r       <= activeSetpointVelocityLimit1; // [RULE_02]
		end
	end

	assign speedLimitSourceA  = limA_r;
	assign speedLimitSourceB  = limB_r;
	assign moveEnable         = moveEnable_r;
	assign moveIsVelocity     = moveIsVel_r;
	assign moveDirNeg         = moveDirNeg_r;
	assign moveVelocity       = moveVel_r;
	assign moveTarget         = moveTarget_r;
	assign positionLoad       = posLoad_r;
	assign positionLoadValue  = posLoadVal_r;
	assign homed              = homed_r;
	assign homingActive       = homingActive_r;
	assign positioningAborted = aborted_r;

	// ==========================================================
	// Assertions
	a_safety_stop: assert property (@(posedge clk_sys) disable iff (rst)
		overLimit |=> !moveEnable && positioningAborted) // [RULE_01]
		else $error("safety overspeed did not stop motion");
	a_limit_source: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(rst) |-> speedLimitSourceB == $past(activeSetpointVelocityLimit1)) // [RULE_02]
		else $error("speed limit b not from element 1");
	a_speed_tel_vel: assert property (@(posedge clk_sys) disable iff (rst)
		(jogSt_r == JOG_IDLE && homeSt_r == HOME_IDLE && speedTel && jogStart1 && !overLimit)
		|=> moveIsVelocity && jogSt_r == JOG_VEL) // [RULE_08]
		else $error("speed telegram jog not velocity");
	a_inc_target: assert property (@(posedge clk_sys) disable iff (rst)
		(jogSt_r == JOG_IDLE && homeSt_r == HOME_IDLE && incMode && jogStart2 && !overLimit)
		|=> moveTarget == $past(actualPosition) + $past(jogChannel2Distance)
		&& moveVelocity == $past(jogChannel2Velocity)) // [RULE_04]
		else $error("incremental jog target wrong");
	a_vel_stop: assert property (@(posedge clk_sys) disable iff (rst)
		(jogSt_r == JOG_VEL && !jogCh2_r && !jogHeld1) |=> !moveEnable) // [RULE_05]
		else $error("velocity jog did not stop");
	a_keep_setpt: assert property (@(posedge clk_sys) disable iff (rst)
		(driveControlWord1[9:8] == 2'b11) |-> !jogStart1 && !jogStart2) // [RULE_06]
		else $error("both jog bits started a channel");
	a_mark_pos: assert property (@(posedge clk_sys) disable iff (rst)
		(homeSt_r == HOME_TO_MARK && homeMark && !absAdjustStart && !overLimit)
		|=> positionLoad && positionLoadValue == $past(homePosition) - $past(homeOffset)
		##1 !positionLoad) // [RULE_15]
		else $error("active mark position wrong");
	a_reverse: assert property (@(posedge clk_sys) disable iff (rst)
		(homeSt_r == HOME_TO_CAM && !refCam && reversingCam && !revCam_r && !overLimit)
		|=> moveDirNeg != $past(moveDirNeg)) // [RULE_16]
		else $error("reversing cam did not flip direction");
	a_adjust: assert property (@(posedge clk_sys) disable iff (rst)
		absAdjustStart |=> positionLoad && positionLoadValue == $past(homePosition)
		&& homed) // [RULE_12]
		else $error("adjustment did not load position");
	c_inc_jog: cover property (@(posedge clk_sys) jogSt_r == JOG_INC ##[1:20] jogSt_r == JOG_IDLE);
	c_vel_jog: cover property (@(posedge clk_sys) jogSt_r == JOG_VEL);
	c_homed: cover property (@(posedge clk_sys) homeSt_r == HOME_TO_POS ##[1:50] homed);
	c_trip: cover property (@(posedge clk_sys) overLimit);
endmodule : jog_and_homing_control

// *** motion_core_model.sv ***
// Behavioural motion core that carries out the block's move commands
`timescale 1ns/10ps
module motion_core_model #(
	parameter int PW = 32,
	parameter int VW = 32
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic                 slowCore,
	input  wire logic                 moveEnable,
	input  wire logic                 moveIsVelocity,
	input  wire logic [VW-1:0]        moveVelocity,
	input  wire logic signed [PW-1:0] moveTarget,
	input  wire logic                 positionLoad,
	input  wire logic signed [PW-1:0] positionLoadValue,
	output logic signed [PW-1:0]      actualPosition,
	output logic [VW-1:0]             motorVelocity,
	output logic                      targetReached
);
	int                   cnt;
	logic signed [PW-1:0] lastTarget;
	// Speed follows the command at once, so an overspeed shows on the first moving cycle
	assign motorVelocity = moveEnable ? moveVelocity : '0;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			actualPosition <= '0;
			targetReached <= 1'b0;
			cnt <= 0;
			lastTarget <= '0;
		end else begin
			lastTarget <= moveTarget;
			if (!moveEnable || moveIsVelocity || moveTarget != lastTarget) begin
				cnt <= 0;
				targetReached <= 1'b0;
			end else if (!targetReached) begin
				cnt <= cnt + 1;
				if (cnt >= (slowCore ? 40 : 2)) begin
					targetReached <= 1'b1;
				end
			end
			if (positionLoad) begin
				actualPosition <= positionLoadValue;
			end else if (moveEnable && !moveIsVelocity && cnt >= (slowCore ? 40 : 2)) begin
				actualPosition <= moveTarget;
			end
		end
	end
endmodule : motion_core_model

// *** test_jog_and_homing_control.sv ***
// Self-checking bench for the jog and homing control block
`timescale 1ns/10ps
module test_jog_and_homing_control
	import jog_home_pkg::*;
();
	typedef struct {logic isVel; logic chk; logic [31:0] vel; logic [31:0] tgt;} move_exp_t;
	logic clk_sys = 1'b0, rst = 1'b1, slowCore = 1'b0;
	logic [7:0] telegramNumber = 8'h07;
	logic [15:0] driveControlWord1 = 16'h0000, positionControlWord2 = 16'h0000;
	logic jogIncrementalSelect = 1'b0, safetyMonitorActive = 1'b0, targetReached;
	logic [31:0] jogChannel1Velocity = 32'h0100, jogChannel2Velocity = 32'h0200;
	logic [31:0] activeSetpointVelocityLimit0 = 32'h00ff_ffff;
	logic [31:0] activeSetpointVelocityLimit1 = 32'h00ff_ffff, motorVelocity, moveVelocity;
	logic [31:0] approachVelCam = 32'h0311, approachVelMark = 32'h0122, approachVelHome = 32'h0533;
	logic [31:0] speedLimitSourceA, speedLimitSourceB;
	logic signed [31:0] jogChannel1Distance = 32'sh0100, jogChannel2Distance = 32'sh0200;
	logic signed [31:0] homePosition = 32'sh1000, homeOffset = 32'sh0010;
	logic signed [31:0] actualPosition, moveTarget, positionLoadValue;
	logic activeHomingStart = 1'b0, passiveHomingEnable = 1'b0, absAdjustStart = 1'b0;
	logic homingDirNeg = 1'b0, encoderZeroMark = 1'b0, externalZeroMark = 1'b0;
	logic controllerRefCam = 1'b0, inputRefCam = 1'b0, referenceCamInputSelect = 1'b0;
	logic reversingCam = 1'b0, moveEnable, moveIsVelocity, moveDirNeg, positionLoad;
	logic homed, homingActive, positioningAborted, prevEn;
	home_mode_t homingMode = MARK_ENCODER;
	logic [31:0] prevVel;
	move_exp_t moveQ[$];
	logic [31:0] loadQ[$];
	int nMismatch = 0, numChecks = 0;
	jog_and_homing_control #(.PW(32), .VW(32)) jog_and_homing_control_i (
		.clk_sys(clk_sys), .rst(rst), .telegramNumber(telegramNumber),
		.driveControlWord1(driveControlWord1), .positionControlWord2(positionControlWord2),
		.jogIncrementalSelect(jogIncrementalSelect), .jogChannel1Velocity(jogChannel1Velocity),
		.jogChannel2Velocity(jogChannel2Velocity), .jogChannel1Distance(jogChannel1Distance),
		.jogChannel2Distance(jogChannel2Distance),
		.activeSetpointVelocityLimit0(activeSetpointVelocityLimit0),
		.activeSetpointVelocityLimit1(activeSetpointVelocityLimit1),
		.safetyMonitorActive(safetyMonitorActive), .motorVelocity(motorVelocity),
		.actualPosition(actualPosition), .targetReached(targetReached),
		.activeHomingStart(activeHomingStart), .passiveHomingEnable(passiveHomingEnable),
		.absAdjustStart(absAdjustStart), .homePosition(homePosition), .homeOffset(homeOffset),
		.homingMode(homingMode), .homingDirNeg(homingDirNeg), .encoderZeroMark(encoderZeroMark),
		.externalZeroMark(externalZeroMark), .controllerRefCam(controllerRefCam),
		.inputRefCam(inputRefCam), .referenceCamInputSelect(referenceCamInputSelect),
		.reversingCam(reversingCam), .approachVelCam(approachVelCam),
		.approachVelMark(approachVelMark), .approachVelHome(approachVelHome),
		.speedLimitSourceA(speedLimitSourceA), .speedLimitSourceB(speedLimitSourceB),
		.moveEnable(moveEnable), .moveIsVelocity(moveIsVelocity), .moveDirNeg(moveDirNeg),
		.moveVelocity(moveVelocity), .moveTarget(moveTarget), .positionLoad(positionLoad),
		.positionLoadValue(positionLoadValue), .homed(homed), .homingActive(homingActive),
		.positioningAborted(positioningAborted));
	motion_core_model #(.PW(32), .VW(32)) motion_core_model_i (
		.clk_sys(clk_sys), .rst(rst), .slowCore(slowCore), .moveEnable(moveEnable),
		.moveIsVelocity(moveIsVelocity), .moveVelocity(moveVelocity), .moveTarget(moveTarget),
		.positionLoad(positionLoad), .positionLoadValue(positionLoadValue),
		.actualPosition(actualPosition), .motorVelocity(motorVelocity),
		.targetReached(targetReached));
	always #5 clk_sys = ~clk_sys;
	// ==========================================================
	// Shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
		numChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : checkVal
	task automatic checkMove(input move_exp_t e);
		checkVal(moveVelocity, e.vel, "move velocity");
		if (e.chk) checkVal({31'h0, moveIsVelocity}, {31'h0, e.isVel}, "move kind");
		if (e.chk && !e.isVel) checkVal(moveTarget, e.tgt, "move target");
	endtask : checkMove
	task automatic noteMove(input logic v, input logic c, input logic [31:0] vel, tgt);
		move_exp_t e;
		e = '{v, c, vel, tgt};
		moveQ.push_back(e);
	endtask : noteMove
	// Returns just after a rising edge so the caller may drive at once
	task automatic waitEn(input logic lvl, input int lim);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (moveEnable !== lvl && n < lim) begin
			n++;
			@(negedge clk_sys);
		end
		checkVal({31'h0, moveEnable}, {31'h0, lvl}, "move enable");
		@(posedge clk_sys);
	endtask : waitEn
	task automatic jog(input int ch, input logic isVel);
		noteMove(isVel, 1'b1, ch == 1 ? jogChannel1Velocity : jogChannel2Velocity,
			actualPosition + (ch == 1 ? jogChannel1Distance : jogChannel2Distance));
		driveControlWord1[7 + ch] <= 1'b1;
		waitEn(1'b1, 4);
		if (isVel) tick(5);
		else waitEn(1'b0, 60);
		driveControlWord1[7 + ch] <= 1'b0;
		waitEn(1'b0, 3);
		tick(1);
	endtask : jog
	task automatic home(input home_mode_t m, input logic sel);
		homingMode <= m;
		referenceCamInputSelect <= sel;
		homingDirNeg <= sel;
		homePosition <= $urandom_range(4096, 65535);
		homeOffset <= $urandom_range(1, 999);
		slowCore <= 1'b1;
		tick(1);
		noteMove(1'b0, 1'b0, m == MARK_ENCODER ? approachVelCam : approachVelMark, '0);
		activeHomingStart <= 1'b1;
		tick(1);
		activeHomingStart <= 1'b0;
		waitEn(1'b1, 4);
		if (m == MARK_ENCODER) begin
			checkVal({31'h0, moveDirNeg}, {31'h0, sel}, "search direction");
			reversingCam <= 1'b1;
			tick(2);
			reversingCam <= 1'b0;
			@(negedge clk_sys);
			checkVal({31'h0, moveDirNeg}, {31'h0, !sel}, "reversed direction");
			tick(1);
			noteMove(1'b0, 1'b0, approachVelMark, '0);
			controllerRefCam <= 1'b1;
			tick(3);
			if (sel) checkVal(moveVelocity, approachVelCam, "cam ignored");
			if (sel) inputRefCam <= 1'b1;
			tick(4);
		end
		loadQ.push_back(homePosition - homeOffset);
		noteMove(1'b0, 1'b1, approachVelHome, homePosition);
		if (m == MARK_DIGITAL) externalZeroMark <= 1'b1;
		else encoderZeroMark <= 1'b1;
		tick(1);
		externalZeroMark <= 1'b0;
		encoderZeroMark <= 1'b0;
		for (int n = 0; n < 90 && homingActive !== 1'b0; n++) @(negedge clk_sys);
		checkVal({31'h0, homed}, 32'h1, "homed");
		tick(1);
		controllerRefCam <= 1'b0;
		inputRefCam <= 1'b0;
		tick(2);
	endtask : home
	task automatic complete_run;
		if (moveQ.size() != 0 || loadQ.size() != 0) nMismatch++;
		$display("Checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	// ==========================================================
	// Result monitor
	always @(negedge clk_sys) begin
		if (!rst && moveEnable === 1'b1 && (prevEn !== 1'b1 || moveVelocity !== prevVel)) begin
			if (moveQ.size() == 0) checkVal(32'h1, 32'h0, "unexpected move");
			else checkMove(moveQ.pop_front());
		end
		if (!rst && positionLoad === 1'b1) begin
			if (loadQ.size() == 0) checkVal(32'h1, 32'h0, "unexpected load");
			else checkVal(positionLoadValue, loadQ.pop_front(), "load value");
		end
		prevEn = moveEnable;
		prevVel = moveVelocity;
	end
	// ==========================================================
	// Stimulus
	initial begin
		logic [7:0] tels[7];
		logic [7:0] tel;
		logic b5;
		logic inc;
		tels = '{8'h07, 8'h09, 8'h6f, 8'h70, 8'h71, 8'h01, 8'h02};
		void'($urandom(72));
		tick(5);
		rst <= 1'b0;
		activeSetpointVelocityLimit0 <= 32'h0100_0000 | $urandom_range(0, 65535);
		activeSetpointVelocityLimit1 <= 32'h0100_0000 | $urandom_range(0, 65535);
		tick(3);
		@(negedge clk_sys);
		checkVal(speedLimitSourceA, activeSetpointVelocityLimit0, "limit a");
		checkVal(speedLimitSourceB, activeSetpointVelocityLimit1, "limit b");
		tick(1);
		for (int i = 0; i < 12; i++) begin
			tel = tels[$urandom_range(0, 6)];
			b5 = 1'($urandom_range(0, 1));
			inc = 1'($urandom_range(0, 1));
			telegramNumber <= tel;
			positionControlWord2 <= {10'h000, b5, 5'h00};
			jogIncrementalSelect <= inc;
			jogChannel1Velocity <= $urandom_range(256, 65535);
			jogChannel2Velocity <= $urandom_range(256, 65535);
			jogChannel1Distance <= $signed($urandom_range(0, 20000)) - 10000;
			jogChannel2Distance <= $signed($urandom_range(0, 20000)) - 10000;
			slowCore <= 1'($urandom_range(0, 1));
			tick(1);
			jog(i % 2 + 1, (tel == 8'h07 || tel == 8'h09) ? 1'b1 :
				(tel >= 8'h6f && tel <= 8'h71) ? !b5 : !inc);
		end
		driveControlWord1[9:8] <= 2'b11;
		tick(5);
		@(negedge clk_sys);
		checkVal({31'h0, moveEnable}, 32'h0, "both bits keep");
		tick(1);
		driveControlWord1[9:8] <= 2'b00;
		telegramNumber <= 8'h07;
		jogChannel1Velocity <= 32'h0000_2000;
		tick(2);
		noteMove(1'b1, 1'b1, 32'h0000_2000, '0);
		driveControlWord1[8] <= 1'b1;
		waitEn(1'b1, 4);
		activeSetpointVelocityLimit0 <= 32'h0000_1000;
		safetyMonitorActive <= 1'b1;
		waitEn(1'b0, 3);
		checkVal({31'h0, positioningAborted}, 32'h1, "aborted");
		driveControlWord1[8] <= 1'b0;
		safetyMonitorActive <= 1'b0;
		activeSetpointVelocityLimit0 <= 32'h00ff_ffff;
		tick(2);
		jog(1, 1'b1);
		checkVal({31'h0, positioningAborted}, 32'h0, "abort cleared");
		home(MARK_ENCODER, 1'b0);
		home(MARK_ENCODER, 1'b1);
		home(MARK_NO_CAM, 1'b0);
		home(MARK_DIGITAL, 1'b0);
		homingMode <= MARK_DIGITAL;
		passiveHomingEnable <= 1'b1;
		tick(2);
		loadQ.push_back(homePosition);
		externalZeroMark <= 1'b1;
		tick(1);
		externalZeroMark <= 1'b0;
		passiveHomingEnable <= 1'b0;
		tick(3);
		loadQ.push_back(homePosition);
		absAdjustStart <= 1'b1;
		tick(1);
		absAdjustStart <= 1'b0;
		tick(3);
		@(negedge clk_sys);
		checkVal({31'h0, moveEnable}, 32'h0, "no motion on load");
		complete_run();
	end
	initial begin
		#200us;
		nMismatch++;
		complete_run();
	end
endmodule : test_jog_and_homing_control
